// file: flash_link_regs.svh
`ifndef FLASH_LINK_REGS_SVH
`define FLASH_LINK_REGS_SVH
// ==========================================
// command opcodes
`define OPC_BUF_LOAD      8'h84
`define OPC_PROG_ERASE    8'h83
`define OPC_PROG_NOERASE  8'h88
`define OPC_LOAD_PROG     8'h82
// ==========================================
// geometry
`define PAGE_COUNT        1024
`define PAGE_BYTES_ALT    9'h108
`define PAGE_BYTES_STD    9'h100
`define MAIN_BYTES        (1024 * 264)
`define ADDR_BYTES        3'h3
`define HDR_BYTES         9'h004
// ==========================================
// timing, in core_clk cycles
`define STEP_CYCLES       4'h4
`define SCK_HALF_CYCLES   4'h4
`define GAP_CYCLES        4'h8
`endif

// file: flash_pkg.sv
package flash_pkg;
	// ==========================================
	// request kinds and the state types of each end
	typedef enum logic [1:0] {
		OP_BUF_LOAD     = 2'b00,   // buffer load only
		OP_PROG_ERASE   = 2'b01,   // buffer to page, erase first
		OP_PROG_NOERASE = 2'b10,   // buffer to page, pre-erased page
		OP_LOAD_PROG    = 2'b11    // load then erase then program
	} op_kind_t;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ERASE = 2'b01,
		ST_PROG  = 2'b10
	} dev_state_t;
	typedef enum logic [1:0] {
		H_IDLE  = 2'b00,
		H_POLL  = 2'b01,
		H_SHIFT = 2'b10,
		H_GAP   = 2'b11
	} host_state_t;
endpackage

// file: flash_link_if.sv
`timescale 1ns/1ps
// ==========================================
// serial link between the host and the flash device
interface flash_link_if;
	logic cs_n;    // chip select, active low
	logic sck;     // serial clock, made by the host
	logic si;      // serial data into the device
	logic ready;   // device ready (high) or busy (low)
	modport device (input cs_n, input sck, input si, output ready);
	modport host   (output cs_n, output sck, output si, input ready);
endinterface

// file: flash_prog_dev.sv
`timescale 1ns/1ps
`include "flash_link_regs.svh"
module flash_prog_dev import flash_pkg::*; (
	input  wire logic     core_clk,
	input  wire logic     nrst,
	input  wire logic     page_264,
	flash_link_if.device  link,
	output logic          busy,
	output logic          erase_program_error_flag
);
	// ==========================================
	// decoding helpers
	// first buffer location from the address bytes
	function automatic logic [8:0] start_ptr(input logic [23:0] a, input logic m);
		start_ptr = m ? a[8:0] : {1'b0, a[7:0]};
	endfunction
	// page number from the address bytes
	function automatic logic [9:0] page_of(input logic [23:0] a, input logic m);
		page_of = m ? a[18:9] : a[17:8];
	endfunction
	// bytes per page in the selected mode
	function automatic logic [8:0] page_len(input logic m);
		page_len = m ? `PAGE_BYTES_ALT : `PAGE_BYTES_STD;
	endfunction
	// opcodes whose data phase fills the buffer
	function automatic logic loads_buf(input logic [7:0] op);
		loads_buf = (op == `OPC_BUF_LOAD) || (op == `OPC_LOAD_PROG);
	endfunction

	// ==========================================
	// link side, clocked by sck
	logic [2:0]  bit_q, bit_d;      // bit within byte
	logic [2:0]  byte_q, byte_d;    // bytes seen, saturates at four
	logic [6:0]  sh_q, sh_d;        // partial byte
	logic [7:0]  op_q, op_d;        // opcode of the frame
	logic [23:0] adr_q, adr_d;      // address bytes
	logic [8:0]  ptr_q, ptr_d;      // next buffer location
	logic        cmd_ok_q, cmd_ok_d;// frame stands on a byte boundary
	logic        lm1_q, lm2_q;      // page mode synchroniser, link side
	logic [7:0]  full;              // completed byte
	logic        wr_en;             // write buffer this edge
	logic [7:0]  buf_mem [0:263];   // data buffer

	// next state of the frame decoder
	always_comb begin
		full     = {sh_q, link.si};
		sh_d     = {sh_q[5:0], link.si};
		bit_d    = bit_q + 3'h1;
		byte_d   = byte_q;
		op_d     = op_q;
		adr_d    = adr_q;
		ptr_d    = ptr_q;
		wr_en    = 1'b0;
		cmd_ok_d = (bit_q == 3'h7) && (byte_q >= `ADDR_BYTES);
		if (bit_q == 3'h7) begin
			if (byte_q == 3'h0) begin
				// first byte is the opcode
				op_d = full;
			end else if (byte_q <= `ADDR_BYTES) begin
				// address bytes, most significant first
				adr_d = {adr_q[15:0], full};
				if (byte_q == `ADDR_BYTES) begin
					ptr_d = start_ptr({adr_q[15:0], full}, lm2_q);
				end
			end else if (loads_buf(op_q)) begin
				// data phase: store and advance with wrap
				wr_en = 1'b1;
				if (ptr_q == page_len(lm2_q) - 9'h1) begin
					ptr_d = 9'h000;
				end else begin
					ptr_d = ptr_q + 9'h1;
				end
			end
			if (byte_q != 3'h4) begin
				byte_d = byte_q + 3'h1;
			end
		end
	end

	// frame counters end with the frame itself
	always_ff @(posedge link.sck or posedge link.cs_n) begin
		if (link.cs_n) begin
			bit_q  <= 3'h0;
			byte_q <= 3'h0;
		end else begin
			bit_q  <= bit_d;
			byte_q <= byte_d;
		end
	end

	// frame contents survive the rise of chip select
	always_ff @(posedge link.sck) begin
		sh_q     <= sh_d;
		op_q     <= op_d;
		adr_q    <= adr_d;
		ptr_q    <= ptr_d;
		cmd_ok_q <= cmd_ok_d;
		lm1_q    <= page_264;
		lm2_q    <= lm1_q;
	end

	// buffer write port, only the link side writes
	always_ff @(posedge link.sck) begin
		if (wr_en) begin
			buf_mem[ptr_q] <= full;
		end
	end

	// ==========================================
	// core side, self-timed operations
	dev_state_t  st_q, st_d;        // operation state
	logic        cs1_q, cs2_q, cs3_q; // chip select synchroniser and history
	logic        cm1_q, cm2_q;      // page mode synchroniser, core side
	logic [9:0]  page_q, page_d;    // target page
	logic [8:0]  idx_q, idx_d;      // byte within page
	logic [3:0]  tick_q, tick_d;    // cycles within one byte step
	logic        err_q, err_d;      // sticky erase/program error
	logic        cs_rise;           // chip select went high
	logic        mem_we;            // write main memory this cycle
	logic [18:0] mem_addr;          // main memory byte address
	logic [7:0]  mem_old;           // current main memory byte
	logic [7:0]  buf_byte;          // buffer byte for this step
	logic [7:0]  mem_new;           // value written back
	logic [7:0]  main_mem [0:`MAIN_BYTES-1]; // main array, 264 per page

	assign cs_rise  = cs2_q & ~cs3_q;
	assign mem_addr = 19'(page_q) * 19'(`PAGE_BYTES_ALT) + 19'(idx_q);
	assign mem_old  = main_mem[mem_addr];
	assign buf_byte = buf_mem[idx_q];

	// next state of the sequencer
	always_comb begin
		st_d    = st_q;
		page_d  = page_q;
		idx_d   = idx_q;
		tick_d  = tick_q;
		err_d   = err_q;
		mem_we  = 1'b0;
		mem_new = mem_old;
		case (st_q)
			ST_IDLE: begin
				// commands start only at a byte-aligned chip select rise
				if (cs_rise && cmd_ok_q) begin
					page_d = page_of(adr_q, cm2_q);
					idx_d  = 9'h000;
					tick_d = 4'h0;
					if (op_q == `OPC_PROG_ERASE || op_q == `OPC_LOAD_PROG) begin
						st_d  = ST_ERASE;
						err_d = 1'b0;
					end else if (op_q == `OPC_PROG_NOERASE) begin
						st_d  = ST_PROG;
						err_d = 1'b0;
					end
				end
			end
			ST_ERASE, ST_PROG: begin
				// one byte per step, busy throughout
				tick_d = tick_q + 4'h1;
				if (tick_q == `STEP_CYCLES - 4'h1) begin
					tick_d = 4'h0;
					mem_we = 1'b1;
					if (st_q == ST_ERASE) begin
						mem_new = 8'hff;
						if (mem_new != 8'hff) begin
							err_d = 1'b1;
						end
					end else begin
						// programming only clears bits
						mem_new = mem_old & buf_byte;
						if (mem_new != buf_byte) begin
							err_d = 1'b1;
						end
					end
					if (idx_q == page_len(cm2_q) - 9'h1) begin
						idx_d = 9'h000;
						st_d  = (st_q == ST_ERASE) ? ST_PROG : ST_IDLE;
					end else begin
						idx_d = idx_q + 9'h1;
					end
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge core_clk) begin
		cs1_q <= link.cs_n;
		cs2_q <= cs1_q;
		cs3_q <= cs2_q;
		cm1_q <= page_264;
		cm2_q <= cm1_q;
		if (!nrst) begin
			st_q   <= ST_IDLE;
			page_q <= 10'h000;
			idx_q  <= 9'h000;
			tick_q <= 4'h0;
			err_q  <= 1'b0;
		end else begin
			st_q   <= st_d;
			page_q <= page_d;
			idx_q  <= idx_d;
			tick_q <= tick_d;
			err_q  <= err_d;
		end
	end

	// main array write port
	always_ff @(posedge core_clk) begin
		if (mem_we) begin
			main_mem[mem_addr] <= mem_new;
		end
	end

	// ==========================================
	// status
	assign busy                     = (st_q != ST_IDLE);
	assign erase_program_error_flag = err_q;
	assign link.ready               = (st_q == ST_IDLE);
endmodule

// file: flash_prog_host.sv
`timescale 1ns/1ps
`include "flash_link_regs.svh"
module flash_prog_host import flash_pkg::*; (
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic       page_264,
	input  wire logic       req_valid,
	output logic            req_ready,
	input  wire op_kind_t   req_op,
	input  wire logic [9:0] req_page,
	input  wire logic [8:0] req_addr,
	input  wire logic [8:0] req_len,
	input  wire logic       wr_valid,
	output logic            wr_ready,
	input  wire logic [7:0] wr_data,
	output logic            busy,
	output logic            done,
	flash_link_if.host      link
);
	// ==========================================
	// command building
	// opcode for each kind of request
	function automatic logic [7:0] opcode_of(input op_kind_t k);
		case (k)
			OP_BUF_LOAD:     opcode_of = `OPC_BUF_LOAD;
			OP_PROG_ERASE:   opcode_of = `OPC_PROG_ERASE;
			OP_PROG_NOERASE: opcode_of = `OPC_PROG_NOERASE;
			default:         opcode_of = `OPC_LOAD_PROG;
		endcase
	endfunction
	// three address bytes with dummy bits as zero
	function automatic logic [23:0] addr_of(input op_kind_t k, input logic [9:0] pg,
			input logic [8:0] ba, input logic m);
		logic [9:0] p;
		logic [8:0] b;
		p = (k == OP_BUF_LOAD) ? 10'h000 : pg;
		b = (k == OP_PROG_ERASE || k == OP_PROG_NOERASE) ? 9'h000 : ba;
		if (m) begin
			addr_of = {5'h00, p, b};
		end else begin
			addr_of = {6'h00, p, b[7:0]};
		end
	endfunction

	// ==========================================
	// frame engine
	host_state_t st_q, st_d;       // frame state
	logic        rd1_q, rd2_q;     // ready synchroniser
	logic        sck_q, sck_d;     // serial clock out
	logic        cs_n_q, cs_n_d;   // chip select out
	logic [7:0]  sh_q, sh_d;       // byte being sent, msb first
	logic [2:0]  bit_q, bit_d;     // bits sent of this byte
	logic [8:0]  byte_q, byte_d;   // bytes sent of this frame
	logic [8:0]  tot_q, tot_d;     // bytes in this frame
	logic [23:0] adr_q, adr_d;     // address bytes
	logic [3:0]  div_q, div_d;     // half period divider
	logic [3:0]  gap_q, gap_d;     // chip select high time
	logic        done_q, done_d;   // frame finished pulse

	// next state of the frame engine
	always_comb begin
		st_d     = st_q;
		sck_d    = sck_q;
		cs_n_d   = cs_n_q;
		sh_d     = sh_q;
		bit_d    = bit_q;
		byte_d   = byte_q;
		tot_d    = tot_q;
		adr_d    = adr_q;
		div_d    = div_q;
		gap_d    = gap_q;
		done_d   = 1'b0;
		wr_ready = 1'b0;
		case (st_q)
			H_IDLE: begin
				// take a request and build its header
				if (req_valid) begin
					sh_d  = opcode_of(req_op);
					adr_d = addr_of(req_op, req_page, req_addr, page_264);
					tot_d = (req_op == OP_BUF_LOAD || req_op == OP_LOAD_PROG) ?
						`HDR_BYTES + req_len : `HDR_BYTES;
					st_d  = H_POLL;
				end
			end
			H_POLL: begin
				// wait for a ready device before selecting it
				if (rd2_q) begin
					cs_n_d = 1'b0;
					bit_d  = 3'h0;
					byte_d = 9'h000;
					div_d  = 4'h0;
					st_d   = H_SHIFT;
				end
			end
			H_SHIFT: begin
				div_d = div_q + 4'h1;
				if (div_q == `SCK_HALF_CYCLES - 4'h1) begin
					div_d = 4'h0;
					if (!sck_q) begin
						// rising edge, device samples si
						sck_d = 1'b1;
					end else if (bit_q != 3'h7) begin
						// falling edge inside a byte
						sck_d = 1'b0;
						sh_d  = {sh_q[6:0], 1'b0};
						bit_d = bit_q + 3'h1;
					end else if (byte_q + 9'h1 == tot_q) begin
						// last bit out, end frame on a byte boundary
						sck_d  = 1'b0;
						cs_n_d = 1'b1;
						gap_d  = 4'h0;
						st_d   = H_GAP;
					end else if (byte_q + 9'h1 < `HDR_BYTES) begin
						// next address byte
						sck_d  = 1'b0;
						bit_d  = 3'h0;
						byte_d = byte_q + 9'h1;
						sh_d   = (byte_q == 9'h000) ? adr_q[23:16] :
							(byte_q == 9'h001) ? adr_q[15:8] : adr_q[7:0];
					end else if (wr_valid) begin
						// next data byte from the user
						wr_ready = 1'b1;
						sck_d    = 1'b0;
						bit_d    = 3'h0;
						byte_d   = byte_q + 9'h1;
						sh_d     = wr_data;
					end else begin
						// no data yet, hold sck high
						div_d = div_q;
					end
				end
			end
			H_GAP: begin
				// chip select high long enough for busy to show
				gap_d = gap_q + 4'h1;
				if (gap_q == `GAP_CYCLES - 4'h1) begin
					done_d = 1'b1;
					st_d   = H_IDLE;
				end
			end
			default: begin
				st_d = H_IDLE;
			end
		endcase
	end

	// frame engine registers
	always_ff @(posedge core_clk) begin
		rd1_q <= link.ready;
		rd2_q <= rd1_q;
		if (!nrst) begin
			st_q   <= H_IDLE;
			sck_q  <= 1'b0;
			cs_n_q <= 1'b1;
			sh_q   <= 8'h00;
			bit_q  <= 3'h0;
			byte_q <= 9'h000;
			tot_q  <= 9'h000;
			adr_q  <= 24'h000000;
			div_q  <= 4'h0;
			gap_q  <= 4'h0;
			done_q <= 1'b0;
		end else begin
			st_q   <= st_d;
			sck_q  <= sck_d;
			cs_n_q <= cs_n_d;
			sh_q   <= sh_d;
			bit_q  <= bit_d;
			byte_q <= byte_d;
			tot_q  <= tot_d;
			adr_q  <= adr_d;
			div_q  <= div_d;
			gap_q  <= gap_d;
			done_q <= done_d;
		end
	end

	// ==========================================
	// outputs
	assign req_ready = (st_q == H_IDLE);
	assign busy      = (st_q != H_IDLE);
	assign done      = done_q;
	assign link.sck  = sck_q;
	assign link.cs_n = cs_n_q;
	assign link.si   = sh_q[7];
endmodule

// file: flash_link_checker.sv
`timescale 1ns/1ps
`include "flash_link_regs.svh"
// ==========================================
// wire checks on the serial link
module flash_link_checker (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic ready
);
	logic [11:0] bits_q, bits_d; // bits seen in this frame
	logic [7:0]  op_q, op_d;     // first byte of the frame
	logic [11:0] low_q, low_d;   // cycles of busy so far
	logic        cs_q, sck_q;    // levels one cycle back
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// ==========================================
	// next values of the helper counters
	always_comb begin
		bits_d = bits_q;
		op_d   = op_q;
		if (cs_q && !cs_n) begin
			bits_d = 12'h000;
		end else if (sck && !sck_q && !cs_n) begin
			bits_d = bits_q + 12'h001;
			if (bits_q < 12'h008) begin
				op_d = {op_q[6:0], si};
			end
		end
		low_d = ready ? 12'h000 : low_q + 12'h001;
	end
	// registers only
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			bits_q <= 12'h000;
			op_q   <= 8'h00;
			low_q  <= 12'h000;
			cs_q   <= 1'b1;
			sck_q  <= 1'b0;
		end else begin
			bits_q <= bits_d;
			op_q   <= op_d;
			low_q  <= low_d;
			cs_q   <= cs_n;
			sck_q  <= sck;
		end
	end
	// ==========================================
	// assertions
	chk_sck_idle: assert property (cs_n |-> !sck)
		else $error("sck high while deselected");
	chk_si_setup: assert property (!cs_n && !$fell(cs_n) && $changed(si) |-> !sck)
		else $error("si moved while sck high");
	chk_sck_high: assert property ($rose(sck) |-> sck [*4])
		else $error("sck high phase short");
	chk_sck_low: assert property ($fell(sck) && !cs_n |-> !sck [*4])
		else $error("sck low phase short");
	chk_frame_whole: assert property ($rose(cs_n) |-> bits_q >= 12'h020 && bits_q[2:0] == 3'h0)
		else $error("frame not whole bytes");
	chk_prog_busy: assert property ($rose(cs_n)
		&& op_q inside {`OPC_PROG_ERASE, `OPC_PROG_NOERASE, `OPC_LOAD_PROG}
		|-> ##[1:5] !ready)
		else $error("program did not go busy");
	chk_load_idle: assert property ($rose(cs_n) && op_q == `OPC_BUF_LOAD |-> ready [*8])
		else $error("buffer load went busy");
	chk_busy_len: assert property ($rose(ready)
		|-> low_q inside {12'h840, 12'h800, 12'h420, 12'h400})
		else $error("busy length wrong");
	chk_host_waits: assert property (!ready |-> cs_n)
		else $error("frame started while busy");
	cover property ($rose(ready));
	cover property ($rose(cs_n) && op_q == `OPC_PROG_NOERASE);
	cover property ($rose(cs_n) && op_q == `OPC_LOAD_PROG);
endmodule

// file: serial_flash_buffer_program_cmds_tb_top.sv
`timescale 1ns/1ps
`include "flash_link_regs.svh"
module serial_flash_buffer_program_cmds_tb_top import flash_pkg::*;;
	typedef struct {
		logic m; op_kind_t op; logic [9:0] pg; logic [8:0] ad;
		logic [8:0] ln; logic [7:0] d0; logic [7:0] dn; logic er;
	} row_t;
	logic        core_clk, nrst, page_264;    // clock, reset, page mode
	logic        req_valid, req_ready;        // request handshake
	op_kind_t    req_op;                      // command kind
	logic [9:0]  req_page;                    // target page
	logic [8:0]  req_addr, req_len;           // start and count
	logic        wr_valid, wr_ready;          // data handshake
	logic [7:0]  wr_data;                     // data byte
	logic        h_busy, done, d_busy, err_flag; // status
	logic [31:0] busy_cnt, nbits, hdr_q;      // monitors
	int          n_fail, total_checks;        // tallies
	row_t        rows [12];                   // ordinary cases
	flash_link_if lnk();
	flash_prog_host u_flash_prog_host (.core_clk(core_clk), .nrst(nrst), .page_264(page_264),
		.req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_page(req_page),
		.req_addr(req_addr), .req_len(req_len), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_data(wr_data), .busy(h_busy), .done(done), .link(lnk));
	flash_prog_dev u_flash_prog_dev (.core_clk(core_clk), .nrst(nrst), .page_264(page_264),
		.link(lnk), .busy(d_busy), .erase_program_error_flag(err_flag));
	flash_link_checker u_flash_link_checker (.core_clk(core_clk), .nrst(nrst),
		.cs_n(lnk.cs_n), .sck(lnk.sck), .si(lnk.si), .ready(lnk.ready));
	// ==========================================
	// clock and wire monitors
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) if (d_busy === 1'b1) busy_cnt <= busy_cnt + 1;
	always @(negedge lnk.cs_n) nbits = 0;
	always @(posedge lnk.sck) if (lnk.cs_n === 1'b0) begin
		if (nbits < 32) hdr_q <= {hdr_q[30:0], lnk.si};
		nbits <= nbits + 1;
	end
	// ==========================================
	// compares and closing
	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t bit got %b exp %b", $time, got, exp);
		end
	endtask
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t value got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// expected busy span and header word
	function automatic int exp_busy(input row_t r);
		int n;
		if (r.op == OP_BUF_LOAD) return 0;
		n = r.m ? `PAGE_BYTES_ALT : `PAGE_BYTES_STD;
		n = n * `STEP_CYCLES;
		return (r.op == OP_PROG_NOERASE) ? n : 2 * n;
	endfunction
	function automatic logic [31:0] exp_hdr(input row_t r);
		logic [9:0] p;
		logic [8:0] a;
		logic [7:0] o;
		p = (r.op == OP_BUF_LOAD) ? 10'h000 : r.pg;
		a = (r.op == OP_PROG_ERASE || r.op == OP_PROG_NOERASE) ? 9'h000 : r.ad;
		case (r.op)
			OP_BUF_LOAD:   o = `OPC_BUF_LOAD;
			OP_PROG_ERASE: o = `OPC_PROG_ERASE;
			OP_LOAD_PROG:  o = `OPC_LOAD_PROG;
			default:       o = `OPC_PROG_NOERASE;
		endcase
		return r.m ? {o, 5'h00, p, a} : {o, 6'h00, p, a[7:0]};
	endfunction
	// one command through the host, then result checks
	task automatic run_op(input row_t r, input logic early);
		int i;
		int k;
		@(posedge core_clk); #1;
		page_264 = r.m;
		req_op = r.op;
		req_page = r.pg;
		req_addr = r.ad;
		req_len = r.ln;
		req_valid = 1'b1;
		busy_cnt = 0;
		chk_bit(req_ready, 1'b1);
		@(posedge core_clk); #1;
		req_valid = 1'b0;
		i = 0;
		k = 0;
		while (i < r.ln && k < 40000) begin
			wr_data = (i == 0) ? r.d0 : r.dn;
			wr_valid = 1'b1;
			@(negedge core_clk);
			k++;
			if (wr_ready === 1'b1) i++;
			@(posedge core_clk); #1;
		end
		wr_valid = 1'b0;
		// every data byte must have been taken by the host
		chk_val(i, r.ln);
		k = 0;
		while (done !== 1'b1 && k < 4000) begin
			@(negedge core_clk);
			k++;
		end
		chk_bit(k < 4000, 1'b1);
		if (early) return;
		k = 0;
		while (d_busy !== 1'b0 && k < 3000) begin
			@(negedge core_clk);
			k++;
		end
		// a device that never returns to ready is a mismatch
		chk_bit(k < 3000, 1'b1);
		chk_val(busy_cnt, exp_busy(r));
		chk_bit(err_flag, r.er);
		chk_val(hdr_q, exp_hdr(r));
		chk_val(nbits, (4 + r.ln) * 8);
	endtask
	task automatic check_idle();
		chk_bit(d_busy, 1'b0);
		chk_bit(lnk.ready, 1'b1);
		chk_bit(err_flag, 1'b0);
		chk_bit(lnk.cs_n, 1'b1);
		chk_bit(h_busy, 1'b0);
	endtask
	// ==========================================
	// main sequence: table rows, then a reset case
	initial begin
		core_clk = 0;
		nrst = 0;
		page_264 = 1;
		req_valid = 0;
		req_op = OP_BUF_LOAD;
		req_page = 0;
		req_addr = 0;
		req_len = 0;
		wr_valid = 0;
		wr_data = 0;
		busy_cnt = 0;
		nbits = 0;
		hdr_q = 0;
		n_fail = 0;
		total_checks = 0;
		rows = '{'{1, OP_BUF_LOAD, 10'h000, 9'h000, 9'h108, 8'h00, 8'h00, 0},
			'{1, OP_PROG_ERASE, 10'h005, 9'h000, 9'h000, 8'h00, 8'h00, 0},
			'{1, OP_BUF_LOAD, 10'h000, 9'h107, 9'h002, 8'h00, 8'hff, 0},
			'{1, OP_PROG_NOERASE, 10'h005, 9'h000, 9'h000, 8'h00, 8'h00, 1},
			'{1, OP_PROG_ERASE, 10'h005, 9'h000, 9'h000, 8'h00, 8'h00, 0},
			'{1, OP_PROG_NOERASE, 10'h005, 9'h000, 9'h000, 8'h00, 8'h00, 0},
			'{1, OP_LOAD_PROG, 10'h009, 9'h106, 9'h003, 8'h00, 8'h00, 0},
			'{0, OP_BUF_LOAD, 10'h000, 9'h000, 9'h100, 8'h00, 8'h00, 0},
			'{0, OP_PROG_ERASE, 10'h3ff, 9'h000, 9'h000, 8'h00, 8'h00, 0},
			'{0, OP_BUF_LOAD, 10'h000, 9'h0ff, 9'h002, 8'h00, 8'hff, 0},
			'{0, OP_PROG_NOERASE, 10'h3ff, 9'h000, 9'h000, 8'h00, 8'h00, 1},
			'{0, OP_LOAD_PROG, 10'h3ff, 9'h0ff, 9'h002, 8'h00, 8'h00, 0}};
		repeat (8) @(posedge core_clk);
		#1 nrst = 1;
		check_idle();
		for (int i = 0; i < 12; i++) begin
			run_op(rows[i], 1'b0);
			$display("row %0d end", i);
		end
		// reset while the page is being erased
		run_op(rows[1], 1'b1);
		repeat (20) @(posedge core_clk);
		#1 chk_bit(d_busy, 1'b1);
		nrst = 0;
		repeat (8) @(posedge core_clk);
		#1 check_idle();
		nrst = 1;
		run_op('{0, OP_BUF_LOAD, 10'h000, 9'h0ff, 9'h001, 8'h5a, 8'h00, 0}, 1'b0);
		$display("reset test end");
		final_report();
	end
	// hang guard
	initial begin
		#900000;
		n_fail++;
		final_report();
	end
endmodule
